// ==== design/p5g_pad_ctrl.sv ====
`timescale 1ns/1ps
module p5g_pad_ctrl
   import p5g_pkg::*;
(
   input wire logic [7:0] func_sel,
   input wire logic [7:0] dir,
   input wire logic [7:0] out_data,
   input wire logic i2c_enable,
   input wire p5g_i2c_out_t i2c_out,
   output p5g_pin_drv_t drv
);
   // ---------------------------------------------------------------
   // per-pin driver decision
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < P5G_PIN_CNT; g++)
      begin : g_pin
         if (g < P5G_WKP_CNT)
         begin : g_low
            // wakeup input keeps the driver off whatever dir holds
            assign drv.o[g] = out_data[g];
            assign drv.oe[g] = dir[g] & ~func_sel[g];
         end
         else
         begin : g_high
            logic i2c_lvl;
            logic od;
            assign i2c_lvl = (g == P5G_BIT_OD_PIN7) ? i2c_out.scl_o : i2c_out.sda_o;
            assign od = func_sel[g];
            // i2c lines only ever pull low
            assign drv.o[g] = i2c_enable ? 1'b0 : out_data[g];
            assign drv.oe[g] = i2c_enable ? ~i2c_lvl :
                               (dir[g] & ~(od & out_data[g]));
         end
      end
   endgenerate
endmodule : p5g_pad_ctrl

// ==== design/p5g_pkg.sv ====
package p5g_pkg;

   // ---------------------------------------------------------------
   // register map (word offsets are byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] P5G_OFS_FUNC_SEL = 4'h0;
   localparam logic [3:0] P5G_OFS_DIR = 4'h4;
   localparam logic [3:0] P5G_OFS_OUT_DATA = 4'h8;
   localparam logic [3:0] P5G_OFS_I2C_CTRL = 4'hc;

   localparam int P5G_PIN_CNT = 8;
   localparam logic [7:0] P5G_RST_FUNC_SEL = 8'h00;
   localparam logic [7:0] P5G_RST_DIR = 8'h00;
   localparam logic [7:0] P5G_RST_OUT_DATA = 8'h00;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int P5G_BIT_OD_PIN7 = 7;
   localparam int P5G_BIT_OD_PIN6 = 6;
   localparam int P5G_BIT_WKP_PIN5 = 5;
   localparam int P5G_BIT_I2C_EN = 0;
   localparam int P5G_WKP_CNT = 6;

   // answer to an unmapped address
   localparam logic [31:0] P5G_UNMAPPED_DATA = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } p5g_pin_drv_t;

   typedef struct packed {
      logic scl_o;
      logic sda_o;
   } p5g_i2c_out_t;

   typedef enum logic [1:0] {
      P5G_IDLE,
      P5G_RESP
   } p5g_bus_state_t;

endpackage : p5g_pkg

// ==== design/p5g_port5.sv ====
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module p5g_port5
   import p5g_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [7:0] pin_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe,
   input wire logic i2c_scl_o,
   input wire logic i2c_sda_o,
   output logic scl_in,
   output logic sda_in,
   output logic [5:0] wakeup_in_n,
   output logic converter_trigger_in
);
   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [7:0] port5_function_select;
   logic [7:0] port5_direction;
   logic [7:0] port5_output_data;
   logic i2c_enable;
   logic [7:0] next_function_select;
   logic [7:0] next_direction;
   logic [7:0] next_output_data;
   logic next_i2c_enable;

   p5g_bus_state_t state;
   p5g_bus_state_t next_state;
   logic [31:0] next_readdata;
   logic next_waitrequest;

   logic [7:0] pin_sync;
   p5g_pin_drv_t drv;
   p5g_i2c_out_t i2c_out;
   p5g_pin_drv_t next_pins;
   logic next_scl_in;
   logic next_sda_in;
   logic [5:0] next_wakeup_in_n;
   logic next_converter_trigger_in;
   logic [7:0] rd_out_data;
   logic wr_hit;
   logic rd_hit;

   // ---------------------------------------------------------------
   // pin sampling
   // ---------------------------------------------------------------
   p5g_sync #(.WIDTH(P5G_PIN_CNT)) u_sync (
      .mclk(mclk),
      .reset(reset),
      .async_in(pin_i),
      .sync_out(pin_sync)
   );

   assign i2c_out.scl_o = i2c_scl_o;
   assign i2c_out.sda_o = i2c_sda_o;

   p5g_pad_ctrl u_pad (
      .func_sel(port5_function_select),
      .dir(port5_direction),
      .out_data(port5_output_data),
      .i2c_enable(i2c_enable),
      .i2c_out(i2c_out),
      .drv(drv)
   );

   // ---------------------------------------------------------------
   // bus slave: one wait state, answer in the second cycle
   // ---------------------------------------------------------------
   assign wr_hit = (state == P5G_RESP) && avs_write && avs_byteenable[0];
   // reads are decoded as the request is taken
   assign rd_hit = (state == P5G_IDLE) && avs_read;

   always_comb
   begin
      for (int i = 0; i < P5G_PIN_CNT; i++)
      begin
         rd_out_data[i] = port5_direction[i] ? port5_output_data[i]
                                             : pin_sync[i];
      end
   end

   always_comb
   begin
      next_state = state;
      next_waitrequest = 1'b1;
      next_readdata = avs_readdata;
      next_function_select = port5_function_select;
      next_direction = port5_direction;
      next_output_data = port5_output_data;
      next_i2c_enable = i2c_enable;
      case (state)
         P5G_IDLE:
         begin
            if (avs_read || avs_write)
            begin
               next_state = P5G_RESP;
               next_waitrequest = 1'b0;
            end
            // loaded together with waitrequest low, so the data already
            // stand at the edge where the master takes them
            if (rd_hit)
            begin
               case (avs_address)
                  P5G_OFS_FUNC_SEL: next_readdata = {24'h000000, port5_function_select};
                  // direction is write-only; reads give zero
                  P5G_OFS_DIR: next_readdata = P5G_UNMAPPED_DATA;
                  P5G_OFS_OUT_DATA: next_readdata = {24'h000000, rd_out_data};
                  P5G_OFS_I2C_CTRL: next_readdata = {31'h00000000, i2c_enable};
                  default: next_readdata = P5G_UNMAPPED_DATA;
               endcase
            end
         end
         P5G_RESP:
         begin
            next_state = P5G_IDLE;
            next_waitrequest = 1'b1;
            if (wr_hit)
            begin
               case (avs_address)
                  P5G_OFS_FUNC_SEL: next_function_select = avs_writedata[7:0];
                  P5G_OFS_DIR: next_direction = avs_writedata[7:0];
                  P5G_OFS_OUT_DATA: next_output_data = avs_writedata[7:0];
                  P5G_OFS_I2C_CTRL: next_i2c_enable = avs_writedata[P5G_BIT_I2C_EN];
                  default: next_i2c_enable = i2c_enable;
               endcase
            end
         end
         default:
         begin
            next_state = P5G_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // pin outputs, registered so every output comes from a flop
   // ---------------------------------------------------------------
   always_comb
   begin
      next_pins = drv;
      next_scl_in = pin_sync[P5G_BIT_OD_PIN7];
      next_sda_in = pin_sync[P5G_BIT_OD_PIN6];
      // wakeup lines idle high unless selected
      next_wakeup_in_n = ~port5_function_select[5:0] | pin_sync[5:0];
      next_converter_trigger_in = port5_function_select[P5G_BIT_WKP_PIN5]
                                  & ~pin_sync[P5G_BIT_WKP_PIN5];
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state <= P5G_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         port5_function_select <= P5G_RST_FUNC_SEL;
         port5_direction <= P5G_RST_DIR;
         port5_output_data <= P5G_RST_OUT_DATA;
         i2c_enable <= 1'b0;
         pin_o <= 8'h00;
         pin_oe <= 8'h00;
         scl_in <= 1'b1;
         sda_in <= 1'b1;
         wakeup_in_n <= 6'h3f;
         converter_trigger_in <= 1'b0;
      end
      else
      begin
         state <= next_state;
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
         port5_function_select <= next_function_select;
         port5_direction <= next_direction;
         port5_output_data <= next_output_data;
         i2c_enable <= next_i2c_enable;
         pin_o <= next_pins.o;
         pin_oe <= next_pins.oe;
         scl_in <= next_scl_in;
         sda_in <= next_sda_in;
         wakeup_in_n <= next_wakeup_in_n;
         converter_trigger_in <= next_converter_trigger_in;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_wakeup_no_drive;
      @(posedge mclk) disable iff (reset)
      port5_function_select[0] |=> !pin_oe[0];
   endproperty
   a_wakeup_no_drive: assert property (p_wakeup_no_drive)
      else $error("wakeup pin 0 driven");

   property p_dir_drives;
      @(posedge mclk) disable iff (reset)
      (port5_direction[1] && !port5_function_select[1]) |=> pin_oe[1];
   endproperty
   a_dir_drives: assert property (p_dir_drives)
      else $error("output pin 1 not driven");

   property p_dir_input;
      @(posedge mclk) disable iff (reset)
      !port5_direction[2] |=> !pin_oe[2];
   endproperty
   a_dir_input: assert property (p_dir_input)
      else $error("input pin 2 driven");

   property p_level;
      @(posedge mclk) disable iff (reset)
      (!i2c_enable) |=> (pin_o[3:0] == $past(port5_output_data[3:0]));
   endproperty
   a_level: assert property (p_level)
      else $error("pin level differs from output data");

   property p_open_drain_high;
      @(posedge mclk) disable iff (reset)
      (!i2c_enable && port5_function_select[7] && port5_output_data[7]) |=> !pin_oe[7];
   endproperty
   a_open_drain_high: assert property (p_open_drain_high)
      else $error("open-drain pin 7 drives high");

   property p_i2c_pull_only;
      @(posedge mclk) disable iff (reset)
      i2c_enable |=> (pin_o[7:6] == 2'b00);
   endproperty
   a_i2c_pull_only: assert property (p_i2c_pull_only)
      else $error("i2c pin drives high");

   property p_read_output;
      @(posedge mclk) disable iff (reset)
      (rd_hit && avs_address == P5G_OFS_OUT_DATA)
      |=> (((avs_readdata[7:0] ^ $past(port5_output_data))
            & $past(port5_direction)) == 8'h00);
   endproperty
   a_read_output: assert property (p_read_output)
      else $error("read of output bits wrong");

   property p_read_pins;
      @(posedge mclk) disable iff (reset)
      (rd_hit && avs_address == P5G_OFS_OUT_DATA)
      |=> (((avs_readdata[7:0] ^ $past(pin_sync))
            & ~$past(port5_direction)) == 8'h00);
   endproperty
   a_read_pins: assert property (p_read_pins)
      else $error("read of input bits wrong");

   property p_trigger;
      @(posedge mclk) disable iff (reset)
      (port5_function_select[5] && !pin_sync[5]) |=> converter_trigger_in;
   endproperty
   a_trigger: assert property (p_trigger)
      else $error("converter trigger missed");

   property p_answer;
      @(posedge mclk) disable iff (reset)
      (state == P5G_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer)
      else $error("bus answer timing wrong");

   property p_wakeup_line;
      @(posedge mclk) disable iff (reset)
      (port5_function_select[1] && !pin_sync[1]) |=> !wakeup_in_n[1];
   endproperty
   a_wakeup_line: assert property (p_wakeup_line)
      else $error("selected wakeup pin 1 not reported");

   property p_wakeup_idle;
      @(posedge mclk) disable iff (reset)
      !port5_function_select[4] |=> wakeup_in_n[4];
   endproperty
   a_wakeup_idle: assert property (p_wakeup_idle)
      else $error("unselected wakeup pin 4 active");

   property p_trigger_idle;
      @(posedge mclk) disable iff (reset)
      !port5_function_select[P5G_BIT_WKP_PIN5] |=> !converter_trigger_in;
   endproperty
   a_trigger_idle: assert property (p_trigger_idle)
      else $error("converter trigger without selection");

   property p_i2c_scl_low;
      @(posedge mclk) disable iff (reset)
      (i2c_enable && !i2c_scl_o) |=> pin_oe[P5G_BIT_OD_PIN7];
   endproperty
   a_i2c_scl_low: assert property (p_i2c_scl_low)
      else $error("i2c clock pull missing");

   property p_i2c_sda_release;
      @(posedge mclk) disable iff (reset)
      (i2c_enable && i2c_sda_o) |=> !pin_oe[P5G_BIT_OD_PIN6];
   endproperty
   a_i2c_sda_release: assert property (p_i2c_sda_release)
      else $error("i2c data line driven while released");
endmodule : p5g_port5

// ==== design/p5g_sync.sv ====
`timescale 1ns/1ps
module p5g_sync
   import p5g_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   always_comb
   begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         stage1 <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule : p5g_sync

// ==== testbench/p5g_board.sv ====
`timescale 1ns/1ps
module p5g_board
   import p5g_pkg::*;
(
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_i
);
   // device drive wins over the board; an undriven pin floats to the pull-up
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (pin_oe[i])
            pin_i[i] = pin_o[i];
         else if (ext_en[i])
            pin_i[i] = ext_val[i];
         else
            pin_i[i] = 1'b1;
      end
   end
endmodule : p5g_board

// ==== testbench/p5g_port5_test.sv ====
`timescale 1ns/1ps
module p5g_port5_test
   import p5g_pkg::*;
   ;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] pin_i, pin_o, pin_oe;
   logic i2c_scl_o = 1'b1;
   logic i2c_sda_o = 1'b1;
   logic scl_in, sda_in, converter_trigger_in;
   logic [5:0] wakeup_in_n;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] ext_en = 8'h00;
   int n_errors = 0;
   int checked = 0;

   always #50 mclk = ~mclk;

   p5g_port5 u_p5g_port5 (.mclk(mclk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
      .i2c_scl_o(i2c_scl_o), .i2c_sda_o(i2c_sda_o), .scl_in(scl_in), .sda_in(sda_in),
      .wakeup_in_n(wakeup_in_n), .converter_trigger_in(converter_trigger_in));

   p5g_board u_p5g_board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_en(ext_en), .pin_i(pin_i));

   task automatic stop_test();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // --------------------------------------------------------------
   // bus master: request held until waitrequest is sampled low
   // --------------------------------------------------------------
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= ~w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0)
         @(posedge mclk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask : wr

   task automatic rd(input string what, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, 4'hf, q);
      chk(what, exp, q);
   endtask : rd

   // pin input needs three edges through synchroniser and output flop; an
   // i2c line request takes one more through the pin output flop
   task automatic settle();
      repeat (5) @(posedge mclk);
   endtask : settle

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_reset();
      chk("pin_oe", 32'h0, {24'h0, pin_oe});
      chk("wakeup_in_n", 32'h3f, {26'h0, wakeup_in_n});
      rd("func_sel", P5G_OFS_FUNC_SEL, 32'h0);
      rd("dir", P5G_OFS_DIR, 32'h0);
      rd("out_data", P5G_OFS_OUT_DATA, 32'hff);
   endtask : t_reset

   task automatic t_gpio();
      logic [31:0] q;
      ext_val <= 8'h42;
      ext_en <= 8'hc3;
      wr(P5G_OFS_DIR, 8'h3c);
      wr(P5G_OFS_OUT_DATA, 8'ha5);
      settle();
      chk("pin_oe", 32'h3c, {24'h0, pin_oe});
      chk("pin_o", 32'h24, {24'h0, pin_o & pin_oe});
      rd("out_data", P5G_OFS_OUT_DATA, 32'h66);
      wr(P5G_OFS_OUT_DATA, 8'h5a);
      rd("out_data b2b", P5G_OFS_OUT_DATA, 32'h5a);
      bus(1'b1, P5G_OFS_OUT_DATA, 8'hff, 4'he, q);
      wr(4'h2, 8'hff);
      rd("unmapped", 4'h2, 32'h0);
      rd("out_data kept", P5G_OFS_OUT_DATA, 32'h5a);
   endtask : t_gpio

   // full variant: upper direction and data bits may be set
   task automatic t_open_drain();
      ext_en <= 8'h00;
      wr(P5G_OFS_DIR, 8'hc0);
      wr(P5G_OFS_OUT_DATA, 8'h80);
      wr(P5G_OFS_FUNC_SEL, 8'hc0);
      settle();
      chk("oe upper od", 32'h1, {30'h0, pin_oe[7:6]});
      chk("o pin6 od", 32'h0, {31'h0, pin_o[6]});
      rd("out_data od", P5G_OFS_OUT_DATA, 32'hbf);
      wr(P5G_OFS_FUNC_SEL, 8'h00);
      settle();
      chk("oe upper pp", 32'h3, {30'h0, pin_oe[7:6]});
   endtask : t_open_drain

   task automatic t_wakeup();
      wr(P5G_OFS_DIR, 8'h3f);
      wr(P5G_OFS_OUT_DATA, 8'h00);
      wr(P5G_OFS_FUNC_SEL, 8'h3f);
      ext_val <= 8'h00;
      ext_en <= 8'h3f;
      settle();
      chk("oe wakeup", 32'h0, {26'h0, pin_oe[5:0]});
      chk("wakeup_in_n all", 32'h0, {26'h0, wakeup_in_n});
      chk("trigger on", 32'h1, {31'h0, converter_trigger_in});
      wr(P5G_OFS_FUNC_SEL, 8'h20);
      settle();
      chk("wakeup_in_n pin5", 32'h1f, {26'h0, wakeup_in_n});
      chk("oe lower", 32'h1f, {27'h0, pin_oe[4:0]});
      wr(P5G_OFS_FUNC_SEL, 8'h00);
      settle();
      chk("trigger off", 32'h0, {31'h0, converter_trigger_in});
      chk("oe pin5", 32'h1, {31'h0, pin_oe[5]});
      ext_en <= 8'h00;
   endtask : t_wakeup

   task automatic t_i2c();
      wr(P5G_OFS_DIR, 8'hc0);
      wr(P5G_OFS_OUT_DATA, 8'hc0);
      wr(P5G_OFS_I2C_CTRL, 8'h01);
      i2c_scl_o <= 1'b0;
      i2c_sda_o <= 1'b1;
      settle();
      chk("oe i2c a", 32'h2, {30'h0, pin_oe[7:6]});
      chk("o i2c", 32'h0, {30'h0, pin_o[7:6] & pin_oe[7:6]});
      chk("scl sda a", 32'h1, {30'h0, scl_in, sda_in});
      i2c_scl_o <= 1'b1;
      i2c_sda_o <= 1'b0;
      settle();
      chk("oe i2c b", 32'h1, {30'h0, pin_oe[7:6]});
      chk("scl sda b", 32'h2, {30'h0, scl_in, sda_in});
      wr(P5G_OFS_I2C_CTRL, 8'h00);
      settle();
      chk("oe port", 32'h3, {30'h0, pin_oe[7:6]});
      chk("o port", 32'h3, {30'h0, pin_o[7:6]});
   endtask : t_i2c

   initial
   begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_gpio();
      t_open_drain();
      t_wakeup();
      t_i2c();
      stop_test();
   end

   // the whole sequence takes about 125 cycles
   initial
   begin
      repeat (3000) @(posedge mclk);
      n_errors++;
      stop_test();
   end
endmodule : p5g_port5_test
